// >>> rtl/lcd_cfg_top.sv
// AXI4-Lite LCD configuration decoder with table access pointer
// Functional notes
// - Mono passive: 00 single4, 01 single8/dual8
// - Colour single: 00 4-bit, 01 F1, 11 F2
// - Colour dual: only 01 valid, dual 8-bit
// - Memory clock ratio by depth, or full rate
// - Power field 00 means software power save
// - Power field 11 normal; 01/10 reserved
// - Mono: green table, index steps once per cycle with an access
// - Colour: auto RGB walk or single table
//
// Chosen here: the register offsets and the AXI4-Lite register port.
module lcd_cfg_top
	import lcd_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output lcd_fmt_e panel_fmt,
	output logic fmt_reserved,
	output logic mclk_en,
	output logic power_save,
	output logic normal_op,
	output logic ps_reserved
);

	// Software-visible configuration
	lcd_pcfg_s pcfg_reg; // Panel selection
	lcd_mode_s mode_reg; // Depth, performance, power
	logic [1:0] lut_sel_reg; // RGB index selection

	// Look-up tables, one per component
	logic [LUT_DW-1:0] lut_mem [3][LUT_DEPTH];

	// Write channel capture
	logic awready_reg;
	logic wready_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic wlane0_reg; // Only the low byte holds register bits
	logic bvalid_reg;
	logic [1:0] bresp_reg;

	// Read channel
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// Decoded outputs
	lcd_fmt_e fmt_reg;
	logic fmt_rsvd_reg;
	logic [2:0] div_cnt_reg;
	logic mclk_en_reg;
	logic psave_reg;
	logic normal_reg;
	logic ps_rsvd_reg;

	// Pointer
	logic [3:0] lut_idx;
	lcd_comp_e lut_comp;

	// Handshakes
	wire logic aw_hs = s_axi_awvalid && awready_reg;
	wire logic w_hs = s_axi_wvalid && wready_reg;
	wire logic b_hs = bvalid_reg && s_axi_bready;
	wire logic ar_hs = s_axi_arvalid && arready_reg;
	wire logic r_hs = rvalid_reg && s_axi_rready;

	// Write fires once address and data are both held
	wire logic do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	wire logic wr_en = do_write && wlane0_reg;
	wire logic [7:0] wbyte = wdata_reg[7:0];

	// Write address decode
	wire logic wa_panel = (awaddr_reg[7:0] == OFS_PANEL);
	wire logic wa_mode = (awaddr_reg[7:0] == OFS_MODE);
	wire logic wa_laddr = (awaddr_reg[7:0] == OFS_LUT_ADDR);
	wire logic wa_ldata = (awaddr_reg[7:0] == OFS_LUT_DATA);
	wire logic wa_stat = (awaddr_reg[7:0] == OFS_STATUS);
	wire logic wa_hit = wa_panel || wa_mode || wa_laddr || wa_ldata || wa_stat;

	// Read address decode
	wire logic [7:0] ra = s_axi_araddr[7:0];
	wire logic ra_ldata = (ra == OFS_LUT_DATA);
	wire logic ra_hit = (ra == OFS_PANEL) || (ra == OFS_MODE) ||
		(ra == OFS_LUT_ADDR) || ra_ldata || (ra == OFS_STATUS);

	// Table access strobes: a data read, a low-byte data write, or both in one cycle, step the pointer once
	wire logic lut_load = wr_en && wa_laddr;
	wire logic lut_wr = wr_en && wa_ldata;
	wire logic lut_rd = ar_hs && ra_ldata;
	wire logic lut_step = lut_wr || lut_rd;
	wire logic [LUT_DW-1:0] lut_q = lut_mem[lut_comp][lut_idx];

	// Register images for reads
	wire logic [7:0] panel_img = {pcfg_reg.active, pcfg_reg.dual,
		pcfg_reg.color, 3'b000, pcfg_reg.width};
	wire logic [7:0] mode_img = {mode_reg.bpp, mode_reg.hp, 3'b000,
		mode_reg.ps};
	wire logic [31:0] stat_img = {18'h0_0000, lut_comp, lut_idx,
		ps_rsvd_reg, normal_reg, psave_reg, fmt_rsvd_reg, fmt_reg};

	// Read data mux; unmapped reads as zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (ra)
			OFS_PANEL: rd_mux[7:0] = panel_img;
			OFS_MODE: rd_mux[7:0] = mode_img;
			OFS_LUT_ADDR: rd_mux[7:0] = {2'b00, lut_sel_reg, lut_idx};
			OFS_LUT_DATA: rd_mux[LUT_DW-1:0] = lut_q;
			OFS_STATUS: rd_mux = stat_img;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Write address/data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 32'h0000_0000;
			wlane0_reg <= 1'b0;
		end else begin
			if (aw_hs) begin
				awready_reg <= 1'b0;
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_hs) begin
				wready_reg <= 1'b0;
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wlane0_reg <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
			// Reopen both channels only once the response is taken
			if (b_hs) begin
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wa_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (b_hs) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Read channel: data one cycle after address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else if (ar_hs) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= ra_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (r_hs) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
		end
	end

	// Configuration registers; status is read-only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pcfg_reg <= lcd_pcfg_s'({PANEL_RST[7:5], PANEL_RST[1:0]});
			mode_reg <= lcd_mode_s'({MODE_RST[7:5], MODE_RST[1:0]});
			lut_sel_reg <= LUT_ADDR_RST[5:4];
		end else if (wr_en) begin
			if (wa_panel) begin
				pcfg_reg.active <= wbyte[PANEL_ACT_BIT];
				pcfg_reg.dual <= wbyte[PANEL_DUAL_BIT];
				pcfg_reg.color <= wbyte[PANEL_COLOR_BIT];
				pcfg_reg.width <= wbyte[PANEL_WIDTH_LSB +: 2];
			end
			if (wa_mode) begin
				mode_reg.bpp <= wbyte[MODE_BPP_LSB +: 2];
				mode_reg.hp <= wbyte[MODE_HP_BIT];
				mode_reg.ps <= wbyte[MODE_PS_LSB +: 2];
			end
			if (wa_laddr) lut_sel_reg <= wbyte[LUT_SEL_LSB +: 2];
		end
	end

	// Table storage, written at the current pointer
	always_ff @(posedge aclk) begin
		if (lut_wr) lut_mem[lut_comp][lut_idx] <= wbyte[LUT_DW-1:0];
	end

	// Pointer and colour sequencer
	lcd_lut_ptr #(
		.IDX_W(4)
	) u_ptr (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(lut_load),
		.load_idx(wbyte[LUT_IDX_LSB +: 4]),
		.step(lut_step),
		.color(pcfg_reg.color),
		.sel(lut_sel_reg),
		.idx(lut_idx),
		.comp(lut_comp)
	);

	// Panel format decode; reserved combos flagged
	wire lcd_fmt_e fmt_dec = lcd_decode_fmt(pcfg_reg);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fmt_reg <= FMT_MONO_S4;
			fmt_rsvd_reg <= 1'b0;
		end else begin
			fmt_reg <= fmt_dec;
			fmt_rsvd_reg <= (fmt_dec == FMT_RSVD);
		end
	end

	// Memory clock enable divider; free-running so a ratio change
	// takes effect at the next aligned terminal count
	wire logic [2:0] mclk_mask = lcd_mclk_mask(mode_reg);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt_reg <= 3'h0;
			mclk_en_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 3'h1;
			mclk_en_reg <= ((div_cnt_reg & mclk_mask) == mclk_mask);
		end
	end

	// Power save field decode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			psave_reg <= 1'b0;
			normal_reg <= 1'b0;
			ps_rsvd_reg <= 1'b0;
		end else begin
			psave_reg <= (mode_reg.ps == 2'b00);
			normal_reg <= (mode_reg.ps == 2'b11);
			ps_rsvd_reg <= (mode_reg.ps == 2'b01) || (mode_reg.ps == 2'b10);
		end
	end

	// Output drive, all from flip-flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign panel_fmt = fmt_reg;
	assign fmt_reserved = fmt_rsvd_reg;
	assign mclk_en = mclk_en_reg;
	assign power_save = psave_reg;
	assign normal_op = normal_reg;
	assign ps_reserved = ps_rsvd_reg;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_mono_width: assert property (
		(!pcfg_reg.active && !pcfg_reg.color && pcfg_reg.width == 2'b01)
		|=> fmt_reg == ($past(pcfg_reg.dual) ? FMT_MONO_D8 : FMT_MONO_S8))
		else $error("mono width decode wrong");

	a_color_single: assert property (
		(!pcfg_reg.active && pcfg_reg.color && !pcfg_reg.dual &&
		pcfg_reg.width[1]) |=>
		fmt_reg == ($past(pcfg_reg.width[0]) ? FMT_COL_S8F2 : FMT_RSVD))
		else $error("colour single decode wrong");

	a_color_dual: assert property (
		(!pcfg_reg.active && pcfg_reg.color && pcfg_reg.dual) |=>
		fmt_rsvd_reg == ($past(pcfg_reg.width) != 2'b01))
		else $error("colour dual reserved flag wrong");

	a_active_width: assert property (
		pcfg_reg.active |=> !fmt_rsvd_reg &&
		fmt_reg == ($past(pcfg_reg.width[0]) ? FMT_TFT12 : FMT_TFT9))
		else $error("active panel width decode wrong");

	a_mclk_full: assert property (
		mode_reg.hp [*2] |-> mclk_en_reg)
		else $error("memory clock not at full rate");

	a_mclk_div8: assert property (
		(!mode_reg.hp && mode_reg.bpp == 2'b00)
		##1 (!mode_reg.hp && mode_reg.bpp == 2'b00 && mclk_en_reg)
		##1 (!mode_reg.hp && mode_reg.bpp == 2'b00)[*7]
		|-> !$past(mclk_en_reg) && !$past(mclk_en_reg, 4) ##1 mclk_en_reg)
		else $error("memory clock divide by eight wrong");

	a_psave_mode: assert property (
		(aresetn && mode_reg.ps == 2'b00) |=> power_save && !normal_op)
		else $error("power save not entered");

	a_normal_mode: assert property (
		(mode_reg.ps == 2'b11) |=> normal_op && !power_save && !ps_reserved)
		else $error("normal operation not flagged");

endmodule

// >>> rtl/lcd_pkg.sv
// Shared constants, types and decode helpers for the LCD config decoder
package lcd_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_PANEL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_LUT_ADDR = 8'h08;
	localparam logic [7:0] OFS_LUT_DATA = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Panel register fields
	localparam int PANEL_ACT_BIT = 7;
	localparam int PANEL_DUAL_BIT = 6;
	localparam int PANEL_COLOR_BIT = 5;
	localparam int PANEL_WIDTH_LSB = 0;

	// Mode register fields
	localparam int MODE_BPP_LSB = 6;
	localparam int MODE_HP_BIT = 5;
	localparam int MODE_PS_LSB = 0;

	// Look-up-table address register fields
	localparam int LUT_SEL_LSB = 4;
	localparam int LUT_IDX_LSB = 0;

	// Status register fields
	localparam int STAT_FMT_LSB = 0;
	localparam int STAT_FMT_RSVD_BIT = 4;
	localparam int STAT_PSAVE_BIT = 5;
	localparam int STAT_NORMAL_BIT = 6;
	localparam int STAT_PS_RSVD_BIT = 7;
	localparam int STAT_IDX_LSB = 8;
	localparam int STAT_COMP_LSB = 12;

	// Reset values
	localparam logic [7:0] PANEL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [5:0] LUT_ADDR_RST = 6'h00;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Table geometry
	localparam int LUT_DEPTH = 16;
	localparam int LUT_DW = 4;

	// Panel interface format
	typedef enum logic [3:0] {
		FMT_MONO_S4, FMT_MONO_S8, FMT_MONO_D8, FMT_COL_S4, FMT_COL_S8F1,
		FMT_COL_S8F2, FMT_COL_D8, FMT_TFT9, FMT_TFT12, FMT_RSVD
	} lcd_fmt_e;

	// Table component currently addressed
	typedef enum logic [1:0] {COMP_RED, COMP_GREEN, COMP_BLUE} lcd_comp_e;

	// Panel selection bits
	typedef struct packed {
		logic active;
		logic dual;
		logic color;
		logic [1:0] width;
	} lcd_pcfg_s;

	// Clocking and power bits
	typedef struct packed {
		logic [1:0] bpp;
		logic hp;
		logic [1:0] ps;
	} lcd_mode_s;

	// Panel selection to interface format
	function automatic lcd_fmt_e lcd_decode_fmt(input lcd_pcfg_s c);
		lcd_fmt_e f;
		f = FMT_RSVD;
		if (c.active) begin
			f = c.width[0] ? FMT_TFT12 : FMT_TFT9;
		end else if (!c.color && !c.dual) begin
			if (c.width == 2'b00) f = FMT_MONO_S4;
			else if (c.width == 2'b01) f = FMT_MONO_S8;
		end else if (!c.color) begin
			if (c.width == 2'b01) f = FMT_MONO_D8;
		end else if (!c.dual) begin
			if (c.width == 2'b00) f = FMT_COL_S4;
			else if (c.width == 2'b01) f = FMT_COL_S8F1;
			else if (c.width == 2'b11) f = FMT_COL_S8F2;
		end else begin
			if (c.width == 2'b01) f = FMT_COL_D8;
		end
		return f;
	endfunction

	// Divider terminal mask: ratio minus one
	function automatic logic [2:0] lcd_mclk_mask(input lcd_mode_s m);
		logic [2:0] k;
		k = 3'h0;
		if (!m.hp) begin
			unique case (m.bpp)
				2'b00: k = 3'h7;
				2'b01: k = 3'h3;
				2'b10: k = 3'h1;
				2'b11: k = 3'h0;
			endcase
		end
		return k;
	endfunction

endpackage

// >>> rtl/lcd_lut_ptr.sv
// Look-up-table access pointer and colour sequencer
module lcd_lut_ptr
	import lcd_pkg::*;
#(
	parameter int IDX_W = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic load,
	input wire logic [IDX_W-1:0] load_idx,
	input wire logic step,
	input wire logic color,
	input wire logic [1:0] sel,
	output logic [IDX_W-1:0] idx,
	output lcd_comp_e comp
);

	lcd_comp_e seq_reg; // Auto sequence position
	lcd_comp_e seq_next;
	logic [IDX_W-1:0] idx_reg;
	logic [IDX_W-1:0] idx_next;
	wire logic auto_mode = color && (sel == 2'b00);
	wire logic wrap = !auto_mode || (seq_reg == COMP_BLUE);

	// Component seen by the table
	always_comb begin
		if (!color) comp = COMP_GREEN;
		else if (sel == 2'b01) comp = COMP_RED;
		else if (sel == 2'b10) comp = COMP_GREEN;
		else if (sel == 2'b11) comp = COMP_BLUE;
		else comp = seq_reg;
	end

	// Next pointer; a fresh address restarts at red
	always_comb begin
		seq_next = seq_reg;
		idx_next = idx_reg;
		if (load) begin
			seq_next = COMP_RED;
			idx_next = load_idx;
		end else if (step) begin
			if (wrap) begin
				idx_next = idx_reg + 1'b1;
				seq_next = COMP_RED;
			end else if (seq_reg == COMP_RED) begin
				seq_next = COMP_GREEN;
			end else begin
				seq_next = COMP_BLUE;
			end
		end
	end

	// Pointer state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_reg <= COMP_RED;
			idx_reg <= '0;
		end else begin
			seq_reg <= seq_next;
			idx_reg <= idx_next;
		end
	end

	assign idx = idx_reg;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_mono_green_step: assert property (
		(step && !load && !color) |=>
		(idx == $past(idx) + 1'b1) && (comp == COMP_GREEN))
		else $error("mono access did not step green table");

	a_auto_rgb_walk: assert property (
		(step && !load && auto_mode && seq_reg != COMP_BLUE) |=>
		(idx == $past(idx)) && (seq_reg == $past(seq_reg) + 2'd1))
		else $error("auto sequence did not move to next colour");

	a_auto_wrap: assert property (
		(step && !load && auto_mode && seq_reg == COMP_BLUE) |=>
		(seq_reg == COMP_RED) && (idx == $past(idx) + 1'b1))
		else $error("auto sequence did not wrap to next index");

	a_single_table: assert property (
		(step && !load && color && sel != 2'b00) |=>
		(idx == $past(idx) + 1'b1))
		else $error("single table access did not advance index");

	a_load_red: assert property (
		load |=> (seq_reg == COMP_RED) && (idx == $past(load_idx)))
		else $error("address write did not restart at red");

endmodule

// >>> verification/lcd_config_decode_lut_access_test.sv
// Self-checking bench for the LCD configuration decoder over AXI4-Lite
module lcd_config_decode_lut_access_test
	import lcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic aclk = 1'b0; // 40 MHz bus clock
	logic aresetn = 1'b0; // Synchronous, active low
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic s_axi_wready;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	lcd_fmt_e panel_fmt;
	logic fmt_reserved;
	logic mclk_en;
	logic power_save;
	logic normal_op;
	logic ps_reserved;
	int num_errors = 0; // Mismatches seen
	int checked = 0; // Comparisons made
	logic [31:0] d; // Last read word
	lcd_fmt_e ef; // Expected format

	// Free-running clock, 25 ns period
	always #12.5 aclk = ~aclk;

	lcd_cfg_top uut (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.panel_fmt(panel_fmt),
		.fmt_reserved(fmt_reserved),
		.mclk_en(mclk_en),
		.power_save(power_save),
		.normal_op(normal_op),
		.ps_reserved(ps_reserved)
	);

	// Compare and report at once
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	// One write; address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		logic aw_ok;
		logic w_ok;
		n = 0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Bounded wait, the watchdog catches a dead bus anyway
		do begin
			@(posedge aclk);
			n++;
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (s_axi_bvalid !== 1'b1 && n < 200);
		s_axi_bready <= 1'b0;
		check(s_axi_bvalid, 1'b1, "write answer");
		check(s_axi_bresp, er, "write response");
	endtask

	// One read; rready stays high until rvalid is sampled
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		input logic [1:0] er);
		int n;
		logic ar_ok;
		n = 0;
		ar_ok = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (!ar_ok && s_axi_arready === 1'b1) begin
				ar_ok = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end while (s_axi_rvalid !== 1'b1 && n < 200);
		v = s_axi_rdata;
		s_axi_rready <= 1'b0;
		check(s_axi_rvalid, 1'b1, "read answer");
		check(s_axi_rresp, er, "read response");
	endtask

	// Reference decode, {active, dual, colour, width}
	function automatic lcd_fmt_e ref_fmt(input logic [4:0] c);
		if (c[4])
			return c[0] ? FMT_TFT12 : FMT_TFT9;
		case (c[3:0])
			4'b0000: return FMT_MONO_S4;
			4'b0001: return FMT_MONO_S8;
			4'b1001: return FMT_MONO_D8;
			4'b0100: return FMT_COL_S4;
			4'b0101: return FMT_COL_S8F1;
			4'b0111: return FMT_COL_S8F2;
			4'b1101: return FMT_COL_D8;
			default: return FMT_RSVD;
		endcase
	endfunction

	// Count enable pulses over a window that is a multiple of every ratio
	task automatic count_mclk(input int ratio);
		int n;
		n = 0;
		repeat (4) @(posedge aclk);
		repeat (64) begin
			@(posedge aclk);
			if (mclk_en === 1'b1)
				n++;
		end
		check(n, 64 / ratio, "memory clock pulses");
	endtask

	// Status pointer field: index then component
	task automatic chk_ptr(input logic [3:0] idx, input logic [1:0] comp);
		rd(OFS_STATUS, d, RESP_OKAY);
		check(d[13:8], {comp, idx}, "table pointer");
	endtask

	// Verdict, the single end of the run
	task automatic conclude();
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog, far beyond the thousand or so cycles the tests need
	initial begin
		repeat (40000) @(posedge aclk);
		num_errors++;
		$display("CHECK FAILED at %0t: timeout", $time);
		conclude();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Reset state: mono single 4-bit, power field 00
		rd(OFS_PANEL, d, RESP_OKAY);
		check(d, 32'h0000_0000, "panel reset");
		rd(OFS_MODE, d, RESP_OKAY);
		check(d, 32'h0000_0000, "mode reset");
		check(power_save, 1'b1, "power save after reset");
		// Every panel selection combination
		for (int c = 0; c < 32; c++) begin
			wr(OFS_PANEL, {24'h00_0000, c[4:2], 3'b000, c[1:0]}, 4'hF, RESP_OKAY);
			repeat (2) @(posedge aclk);
			ef = ref_fmt(c[4:0]);
			check(panel_fmt, ef, "format");
			check(fmt_reserved, ef == FMT_RSVD, "reserved flag");
			rd(OFS_STATUS, d, RESP_OKAY);
			check(d[4:0], {ef == FMT_RSVD, ef}, "status format");
		end
		// Cleared strobe leaves the panel register alone
		wr(OFS_PANEL, 32'h0000_00E1, 4'h0, RESP_OKAY);
		rd(OFS_PANEL, d, RESP_OKAY);
		check(d[7:0], 8'hE3, "masked write");
		// All four power field codes
		for (int p = 0; p < 4; p++) begin
			wr(OFS_MODE, {30'h0000_0000, p[1:0]}, 4'hF, RESP_OKAY);
			repeat (2) @(posedge aclk);
			check(power_save, p == 0, "power save");
			check(normal_op, p == 3, "normal op");
			check(ps_reserved, p == 1 || p == 2, "power reserved");
		end
		// Memory clock ratio for each depth, then high performance
		for (int h = 0; h < 2; h++) begin
			for (int b = 0; b < 4; b++) begin
				wr(OFS_MODE, {24'h00_0000, b[1:0], h[0], 5'h03}, 4'hF, RESP_OKAY);
				count_mclk(h ? 1 : 8 >> b);
			end
		end
		// Mono: entries land in green whatever the select holds
		wr(OFS_PANEL, 32'h0000_0000, 4'hF, RESP_OKAY);
		wr(OFS_LUT_ADDR, 32'h0000_0013, 4'hF, RESP_OKAY);
		for (int i = 0; i < 3; i++)
			wr(OFS_LUT_DATA, 32'h0000_0005 + i, 4'hF, RESP_OKAY);
		chk_ptr(4'h6, COMP_GREEN);
		// Colour auto walk: one write steps red to green
		wr(OFS_PANEL, 32'h0000_0020, 4'hF, RESP_OKAY);
		wr(OFS_LUT_ADDR, 32'h0000_000E, 4'hF, RESP_OKAY);
		wr(OFS_LUT_DATA, 32'h0000_0001, 4'hF, RESP_OKAY);
		chk_ptr(4'hE, COMP_GREEN);
		// New address mid-triple restarts at red
		wr(OFS_LUT_ADDR, 32'h0000_000E, 4'hF, RESP_OKAY);
		chk_ptr(4'hE, COMP_RED);
		for (int i = 0; i < 6; i++)
			wr(OFS_LUT_DATA, 32'h0000_0009 + i, 4'hF, RESP_OKAY);
		chk_ptr(4'h0, COMP_RED);
		// Single tables read back what the walk wrote
		for (int t = 1; t < 4; t++) begin
			wr(OFS_LUT_ADDR, {26'h000_0000, t[1:0], 4'hE}, 4'hF, RESP_OKAY);
			for (int i = 0; i < 2; i++) begin
				rd(OFS_LUT_DATA, d, RESP_OKAY);
				check(d[3:0], 4'h9 + 3 * i + t - 1, "single table");
			end
			chk_ptr(4'h0, 2'(t - 1));
		end
		// Green table still holds the mono entries
		wr(OFS_LUT_ADDR, 32'h0000_0023, 4'hF, RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			rd(OFS_LUT_DATA, d, RESP_OKAY);
			check(d[3:0], 4'h5 + i, "green entry");
		end
		// Unmapped place on both paths
		wr(8'h14, 32'h0000_00FF, 4'hF, RESP_SLVERR);
		rd(8'h14, d, RESP_SLVERR);
		check(d, 32'h0000_0000, "unmapped read data");
		conclude();
	end
endmodule
